// *** rtl/sbeh_cfg.svh ***
`ifndef SBEH_CFG_SVH
`define SBEH_CFG_SVH

// register byte offsets on the apb slave
`define SBEH_ADDR_W        12
`define SBEH_OFF_CTRL      12'h000
`define SBEH_OFF_PSTAT     12'h004
`define SBEH_OFF_SSTAT     12'h008

// control register fields
`define SBEH_CTRL_W        3
`define SBEH_CTRL_SERR_EN  0
`define SBEH_CTRL_MA_MODE  1
`define SBEH_CTRL_DISCARD  2
`define SBEH_CTRL_RST      3'h0

// status register fields, write one to clear
`define SBEH_STAT_W        5
`define SBEH_STAT_DET_PAR  0
`define SBEH_STAT_DPAR_RPT 1
`define SBEH_STAT_RCV_MA   2
`define SBEH_STAT_SC_DISC  3
`define SBEH_STAT_SERR_SIG 4
`define SBEH_STAT_RST      5'h00

// error completion message codes
`define SBEH_SCM_CLASS     4'h1
`define SBEH_IDX_MA        8'h00
`define SBEH_IDX_WPAR      8'h02

// bus side encoding
`define SBEH_SIDE_PRI      1'b0
`define SBEH_SIDE_SEC      1'b1

`endif

// *** rtl/sbeh_pkg.sv ***
package sbeh_pkg;

  // transaction kinds seen by the error logic
  typedef enum logic [2:0] {
    SBEH_KIND_READ,
    SBEH_KIND_NPW,
    SBEH_KIND_PW,
    SBEH_KIND_SC,
    SBEH_KIND_SCM,
    SBEH_KIND_OTHER
  } sbeh_kind_e;

  // events reported by the forwarding logic
  typedef enum logic [2:0] {
    SBEH_EV_ORIG_DATA,
    SBEH_EV_DEST_PERR,
    SBEH_EV_DEST_MA,
    SBEH_EV_DEST_SPLIT,
    SBEH_EV_DEST_DONE
  } sbeh_event_e;

  // context tracking state
  typedef enum logic {
    SBEH_CTX_IDLE,
    SBEH_CTX_BUSY
  } sbeh_ctx_e;

endpackage

// *** rtl/sbeh_error_handler.sv ***
`timescale 1ns/1ps
`include "sbeh_cfg.svh"

// Function
// - originating side is the side acting as target
// - forward data, enables, parity unchanged
// - immediate read parity error: status, PERR
// - keep fetching after read parity error
// - write parity error: discard or forward
// - never Retry or Target-Abort on parity
// - discard option delays split response
// - after split response always forward write
// - destination PERR, immediate end: error message
// - destination split response: end normally
// - completion parity error: PERR, forward bad
// - message parity error: discard, SERR
// - destination PERR on completion: status only
// - forward messages without decoding them
// - posted write parity: PERR, forward bad
// - clean posted write, destination PERR: SERR
// - master-abort on request: bridge error message
// - dword master-abort message replaces completion
// - exclusive accesses handled identically
// - posted write master-abort: disconnect, discard
// - master-abort mode gates posted write SERR
// - completion master-abort: discard, SERR, status
// - generated messages carry bridge error class
// - master-abort message index is zero
module sbeh_error_handler
  import sbeh_pkg::*;
#(
  parameter int DATA_W = 64,
  parameter int BE_W   = 8
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [`SBEH_ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]             pwdata_i,
  output logic      [31:0]             prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  input  wire logic                    txn_start_i,
  input  wire sbeh_kind_e              txn_kind_i,
  input  wire logic                    txn_req_side_i,
  input  wire logic                    txn_cpl_side_i,
  input  wire logic                    txn_dword_i,
  input  wire logic                    ev_valid_i,
  input  wire sbeh_event_e             ev_code_i,
  input  wire logic                    ev_par_err_i,
  input  wire logic [DATA_W-1:0]       ad_i,
  input  wire logic [BE_W-1:0]         cbe_n_i,
  input  wire logic                    par_i,
  input  wire logic                    par64_i,
  output logic      [DATA_W-1:0]       ad_o,
  output logic      [BE_W-1:0]         cbe_n_o,
  output logic                         par_o,
  output logic                         par64_o,
  output logic                         perr_pri_o,
  output logic                         perr_sec_o,
  output logic                         serr_o,
  output logic                         resp_dt_o,
  output logic                         resp_split_o,
  output logic                         fwd_o,
  output logic                         fwd_bad_par_o,
  output logic                         discard_o,
  output logic                         disconnect_o,
  output logic                         fetch_more_o,
  output logic                         scm_valid_o,
  output logic      [3:0]              scm_class_o,
  output logic      [7:0]              scm_index_o,
  output logic                         scm_replace_o
);

  // register state
  logic [`SBEH_CTRL_W-1:0]       ctrl;
  logic [1:0][`SBEH_STAT_W-1:0]  stat;
  logic [`SBEH_CTRL_W-1:0]       next_ctrl;
  logic [1:0][`SBEH_STAT_W-1:0]  next_stat;
  logic [1:0][`SBEH_STAT_W-1:0]  set_v;
  logic [1:0][`SBEH_STAT_W-1:0]  clr_v;
  logic [31:0]                   next_prdata;
  logic                          next_pready;
  logic                          next_pslverr;

  // transaction context
  sbeh_ctx_e                     ctx_state;
  sbeh_ctx_e                     next_ctx_state;
  sbeh_kind_e                    ctx_kind;
  sbeh_kind_e                    next_ctx_kind;
  logic                          ctx_orig;
  logic                          next_ctx_orig;
  logic                          ctx_oerr;
  logic                          next_ctx_oerr;
  logic                          ctx_derr;
  logic                          next_ctx_derr;
  logic                          ctx_split;
  logic                          next_ctx_split;
  logic                          ctx_dword;
  logic                          next_ctx_dword;
  logic                          ctx_dest;

  // registered event answers
  logic [1:0]                    perr_q;
  logic [1:0]                    next_perr;
  logic                          next_serr;
  logic                          next_resp_dt;
  logic                          next_resp_split;
  logic                          next_fwd;
  logic                          next_fwd_bad;
  logic                          next_discard;
  logic                          next_disconnect;
  logic                          next_fetch_more;
  logic                          next_scm_valid;
  logic [7:0]                    next_scm_index;
  logic                          next_scm_replace;

  logic                          ev_hit;
  logic                          apb_done;
  logic                          serr_en;
  logic                          ma_mode;
  logic                          disc_opt;

  assign ctx_dest = ~ctx_orig;
  assign ev_hit   = ev_valid_i && (ctx_state == SBEH_CTX_BUSY) && !txn_start_i;
  assign apb_done = psel_i && penable_i && pready_o;
  assign serr_en  = ctrl[`SBEH_CTRL_SERR_EN];
  assign ma_mode  = ctrl[`SBEH_CTRL_MA_MODE];
  assign disc_opt = ctrl[`SBEH_CTRL_DISCARD];
  assign perr_pri_o = perr_q[0];
  assign perr_sec_o = perr_q[1];

  // apb slave: one wait state, write effect at completion edge
  always_comb begin
    next_pready  = psel_i && penable_i && !pready_o;
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    next_ctrl    = ctrl;
    clr_v        = '0;
    if (next_pready) begin
      unique case (paddr_i)
        `SBEH_OFF_CTRL:  next_prdata = {29'h0, ctrl};
        `SBEH_OFF_PSTAT: next_prdata = {27'h0, stat[0]};
        `SBEH_OFF_SSTAT: next_prdata = {27'h0, stat[1]};
        default:         next_pslverr = 1'b1;
      endcase
      if (pwrite_i) begin
        next_prdata = 32'h0000_0000;
      end
    end
    if (apb_done && pwrite_i) begin
      unique case (paddr_i)
        `SBEH_OFF_CTRL:  next_ctrl = pwdata_i[`SBEH_CTRL_W-1:0];
        `SBEH_OFF_PSTAT: clr_v[0] = pwdata_i[`SBEH_STAT_W-1:0];
        `SBEH_OFF_SSTAT: clr_v[1] = pwdata_i[`SBEH_STAT_W-1:0];
        default:         clr_v    = '0;
      endcase
    end
    // hardware set wins over software clear
    next_stat[0] = (stat[0] & ~clr_v[0]) | set_v[0];
    next_stat[1] = (stat[1] & ~clr_v[1]) | set_v[1];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl      <= `SBEH_CTRL_RST;
      stat[0]   <= `SBEH_STAT_RST;
      stat[1]   <= `SBEH_STAT_RST;
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      stat      <= next_stat;
      prdata_o  <= next_prdata;
      pready_o  <= next_pready;
      pslverr_o <= next_pslverr;
    end
  end

  // error decision per transaction event; exclusive flag has no say
  always_comb begin
    next_ctx_state   = ctx_state;
    next_ctx_kind    = ctx_kind;
    next_ctx_orig    = ctx_orig;
    next_ctx_oerr    = ctx_oerr;
    next_ctx_derr    = ctx_derr;
    next_ctx_split   = ctx_split;
    next_ctx_dword   = ctx_dword;
    set_v            = '0;
    next_perr        = 2'b00;
    next_serr        = 1'b0;
    next_resp_dt     = 1'b0;
    next_resp_split  = 1'b0;
    next_fwd         = 1'b0;
    next_fwd_bad     = 1'b0;
    next_discard     = 1'b0;
    next_disconnect  = 1'b0;
    next_scm_valid   = 1'b0;
    next_scm_index   = scm_index_o;
    next_scm_replace = 1'b0;
    if (txn_start_i) begin
      next_ctx_state = SBEH_CTX_BUSY;
      next_ctx_kind  = txn_kind_i;
      // completions originate nearest the completer
      next_ctx_orig  = (txn_kind_i == SBEH_KIND_SC || txn_kind_i == SBEH_KIND_SCM) ?
                       txn_cpl_side_i : txn_req_side_i;
      next_ctx_oerr  = 1'b0;
      next_ctx_derr  = 1'b0;
      next_ctx_dword = txn_dword_i;
      // early split response when writes are never discarded
      next_ctx_split  = (txn_kind_i == SBEH_KIND_NPW) && !disc_opt;
      next_resp_split = (txn_kind_i == SBEH_KIND_NPW) && !disc_opt;
    end else if (ev_hit) begin
      unique case (ev_code_i)
        SBEH_EV_ORIG_DATA: begin
          next_fwd = 1'b1;
          if (ev_par_err_i) begin
            set_v[ctx_orig][`SBEH_STAT_DET_PAR] = 1'b1;
            next_ctx_oerr = 1'b1;
            unique case (ctx_kind)
              SBEH_KIND_NPW: begin
                next_perr[ctx_orig] = 1'b1;
                if (ctx_split) begin
                  next_fwd_bad = 1'b1;
                end else begin
                  // data transfer, never retry or abort
                  next_resp_dt   = 1'b1;
                  next_discard   = 1'b1;
                  next_fwd       = 1'b0;
                  next_ctx_state = SBEH_CTX_IDLE;
                end
              end
              SBEH_KIND_SCM: begin
                next_discard   = 1'b1;
                next_fwd       = 1'b0;
                next_serr      = serr_en;
                next_ctx_state = SBEH_CTX_IDLE;
              end
              default: begin
                next_perr[ctx_orig] = 1'b1;
                next_fwd_bad        = 1'b1;
              end
            endcase
          end else if (ctx_kind == SBEH_KIND_NPW && !ctx_split) begin
            // split response only after parity was checked
            next_resp_split = 1'b1;
            next_ctx_split  = 1'b1;
          end
        end
        SBEH_EV_DEST_PERR: begin
          next_ctx_derr = 1'b1;
          set_v[ctx_dest][`SBEH_STAT_DPAR_RPT] = 1'b1;
          if (ctx_kind == SBEH_KIND_READ) begin
            set_v[ctx_dest][`SBEH_STAT_DET_PAR] = 1'b1;
            next_perr[ctx_dest] = 1'b1;
            next_fwd_bad        = 1'b1;
          end else if (ctx_kind == SBEH_KIND_PW && !ctx_oerr) begin
            next_serr = serr_en;
          end
        end
        SBEH_EV_DEST_MA: begin
          set_v[ctx_dest][`SBEH_STAT_RCV_MA] = 1'b1;
          next_ctx_state = SBEH_CTX_IDLE;
          unique case (ctx_kind)
            SBEH_KIND_PW: begin
              next_disconnect = 1'b1;
              next_discard    = 1'b1;
              next_serr       = serr_en && ma_mode;
            end
            SBEH_KIND_SC, SBEH_KIND_SCM: begin
              set_v[ctx_dest][`SBEH_STAT_SC_DISC] = 1'b1;
              next_discard = 1'b1;
              next_serr    = serr_en;
            end
            default: begin
              next_scm_valid   = 1'b1;
              next_scm_index   = `SBEH_IDX_MA;
              next_scm_replace = ctx_dword;
            end
          endcase
        end
        SBEH_EV_DEST_SPLIT: begin
          // target will complete later; nothing more to do
          next_ctx_state = SBEH_CTX_IDLE;
        end
        SBEH_EV_DEST_DONE: begin
          next_ctx_state = SBEH_CTX_IDLE;
          if ((ctx_kind == SBEH_KIND_NPW || ctx_kind == SBEH_KIND_OTHER) && ctx_derr) begin
            next_scm_valid   = 1'b1;
            next_scm_index   = `SBEH_IDX_WPAR;
            next_scm_replace = ctx_dword;
          end
        end
        default: begin
          next_ctx_state = ctx_state;
        end
      endcase
    end
    if (next_serr) begin
      set_v[0][`SBEH_STAT_SERR_SIG] = 1'b1;
    end
    // reads keep fetching until master-abort, split or done ends the context
    next_fetch_more = (next_ctx_state == SBEH_CTX_BUSY) &&
                      (next_ctx_kind == SBEH_KIND_READ);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctx_state     <= SBEH_CTX_IDLE;
      ctx_kind      <= SBEH_KIND_READ;
      ctx_orig      <= `SBEH_SIDE_PRI;
      ctx_oerr      <= 1'b0;
      ctx_derr      <= 1'b0;
      ctx_split     <= 1'b0;
      ctx_dword     <= 1'b0;
      perr_q        <= 2'b00;
      serr_o        <= 1'b0;
      resp_dt_o     <= 1'b0;
      resp_split_o  <= 1'b0;
      fwd_o         <= 1'b0;
      fwd_bad_par_o <= 1'b0;
      discard_o     <= 1'b0;
      disconnect_o  <= 1'b0;
      fetch_more_o  <= 1'b0;
      scm_valid_o   <= 1'b0;
      scm_class_o   <= 4'h0;
      scm_index_o   <= 8'h00;
      scm_replace_o <= 1'b0;
    end else begin
      ctx_state     <= next_ctx_state;
      ctx_kind      <= next_ctx_kind;
      ctx_orig      <= next_ctx_orig;
      ctx_oerr      <= next_ctx_oerr;
      ctx_derr      <= next_ctx_derr;
      ctx_split     <= next_ctx_split;
      ctx_dword     <= next_ctx_dword;
      perr_q        <= next_perr;
      serr_o        <= next_serr;
      resp_dt_o     <= next_resp_dt;
      resp_split_o  <= next_resp_split;
      fwd_o         <= next_fwd;
      fwd_bad_par_o <= next_fwd_bad;
      discard_o     <= next_discard;
      disconnect_o  <= next_disconnect;
      fetch_more_o  <= next_fetch_more;
      scm_valid_o   <= next_scm_valid;
      scm_class_o   <= `SBEH_SCM_CLASS;
      scm_index_o   <= next_scm_index;
      scm_replace_o <= next_scm_replace;
    end
  end

  // destination data path, messages pass undecoded, bad parity kept
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ad_o    <= '0;
      cbe_n_o <= '1;
      par_o   <= 1'b0;
      par64_o <= 1'b0;
    end else begin
      ad_o    <= ad_i;
      cbe_n_o <= cbe_n_i;
      par_o   <= par_i;
      par64_o <= par64_i;
    end
  end

  // checks
  a_dp_passthru: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 (ad_o == $past(ad_i)) && (par_o == $past(par_i)) && (par64_o == $past(par64_i)))
    else $error("data path altered");

  a_npw_discard_dt: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ev_hit && ev_code_i == SBEH_EV_ORIG_DATA && ev_par_err_i && ctx_kind == SBEH_KIND_NPW
     && !ctx_split) |=> resp_dt_o && discard_o && !fwd_o && !resp_split_o)
    else $error("npw parity error not discarded");

  a_parity_resp_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ev_hit && ev_code_i == SBEH_EV_ORIG_DATA && ev_par_err_i && ctx_kind == SBEH_KIND_NPW)
    |=> (resp_dt_o != ctx_split) && (perr_pri_o || perr_sec_o))
    else $error("bad answer to write parity error");

  a_split_after_chk: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (resp_split_o && $past(disc_opt)) |->
    $past(ev_hit && ev_code_i == SBEH_EV_ORIG_DATA && !ev_par_err_i))
    else $error("split response before parity check");

  a_ma_scm_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ev_hit && ev_code_i == SBEH_EV_DEST_MA && ctx_kind == SBEH_KIND_READ) |=>
    scm_valid_o && scm_class_o == 4'h1 && scm_index_o == 8'h00 && !discard_o)
    else $error("master-abort message wrong");

  a_pw_ma_disc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ev_hit && ev_code_i == SBEH_EV_DEST_MA && ctx_kind == SBEH_KIND_PW) |=>
    disconnect_o && discard_o && (serr_o == $past(serr_en && ma_mode)) && !scm_valid_o)
    else $error("posted write master-abort handling");

  a_sc_ma_serr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ev_hit && ev_code_i == SBEH_EV_DEST_MA && ctx_kind == SBEH_KIND_SC) |=>
    discard_o && serr_o == $past(serr_en) ##1 stat[0][`SBEH_STAT_SERR_SIG] == $past(serr_en, 2)
    || !$past(serr_en, 2))
    else $error("completion master-abort handling");

  a_scm_perr_disc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ev_hit && ev_code_i == SBEH_EV_ORIG_DATA && ev_par_err_i && ctx_kind == SBEH_KIND_SCM)
    |=> discard_o && !fwd_o && (serr_o == $past(serr_en)) ##1 ctx_state == SBEH_CTX_IDLE)
    else $error("message parity error handling");

  a_pw_clean_serr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ev_hit && ev_code_i == SBEH_EV_DEST_PERR && ctx_kind == SBEH_KIND_PW) |=>
    serr_o == ($past(serr_en) && !$past(ctx_oerr)))
    else $error("posted write destination perr serr");

  a_read_perr_dest: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ev_hit && ev_code_i == SBEH_EV_DEST_PERR && ctx_kind == SBEH_KIND_READ) |=>
    perr_q[$past(ctx_dest)] && !perr_q[$past(ctx_orig)] && fwd_bad_par_o && fetch_more_o)
    else $error("read parity error handling");

endmodule

// *** tb/sbeh_agent_model.sv ***
`timescale 1ns/1ps
// requester and completer agents on both buses, seen as context and event strobes
module sbeh_agent_model
  import sbeh_pkg::*;
#(
  parameter int DATA_W = 64,
  parameter int BE_W   = 8
) (
  input  wire logic         clk_i,
  output logic              txn_start_o,
  output sbeh_kind_e        txn_kind_o,
  output logic              txn_req_side_o,
  output logic              txn_cpl_side_o,
  output logic              txn_dword_o,
  output logic              ev_valid_o,
  output sbeh_event_e       ev_code_o,
  output logic              ev_par_err_o,
  output logic [DATA_W-1:0] ad_o,
  output logic [BE_W-1:0]   cbe_n_o,
  output logic              par_o,
  output logic              par64_o
);
  // idle bus at time zero
  initial begin
    {txn_start_o, txn_req_side_o, txn_cpl_side_o, txn_dword_o} = 4'h0;
    {ev_valid_o, ev_par_err_o, par_o, par64_o} = 4'h0;
    txn_kind_o = SBEH_KIND_READ;
    ev_code_o = SBEH_EV_ORIG_DATA;
    ad_o = '0;
    cbe_n_o = '1;
  end

  // new transaction context, one-cycle strobe
  task automatic start(input sbeh_kind_e k, input logic rq, input logic cp, input logic dw);
    @(posedge clk_i);
    txn_start_o <= 1'h1;
    txn_kind_o <= k;
    txn_req_side_o <= rq;
    txn_cpl_side_o <= cp;
    txn_dword_o <= dw;
    @(posedge clk_i);
    txn_start_o <= 1'h0;
    #1;
  endtask

  // one event with its data phase; released lines show the inverse
  task automatic send_ev(input sbeh_event_e c, input logic pe, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    ev_valid_o <= 1'h1;
    ev_code_o <= c;
    ev_par_err_o <= pe;
    ad_o <= d;
    cbe_n_o <= d[BE_W-1:0];
    par_o <= (^d) ^ pe;  // bad parity when pe is set
    par64_o <= pe;
    @(posedge clk_i);
    ev_valid_o <= 1'h0;
    ad_o <= ~d;
    cbe_n_o <= ~d[BE_W-1:0];
    #1;
  endtask
endmodule

// *** tb/tb_sbeh_error_handler.sv ***
`timescale 1ns/1ps
`include "sbeh_cfg.svh"
// bench for the bridge error handler
module tb_sbeh_error_handler
  import sbeh_pkg::*;
;
  logic            clk = 1'h0;
  logic            rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata;
  logic            t_st, t_rq, t_cp, t_dw, e_v, e_pe, p_i, p64_i;
  sbeh_kind_e      t_k;
  sbeh_event_e     e_c;
  logic [63:0]     a_i, a_o, pat;
  logic [7:0]      c_i, c_o, idx;
  logic            po, p64o, pp, ps, se, dt, sp, fw, fb, dc, dn, fm, sv, rp;
  logic [3:0]      cls;
  int              error_cnt = 0;
  int              checks_done = 0;
  wire logic [9:0] obs = {pp, ps, se, dt, sp, fw, fb, dc, dn, sv};

  // 200 MHz clock
  always #2.5 clk = ~clk;

  sbeh_error_handler i_sbeh_error_handler (
    .clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .txn_start_i(t_st), .txn_kind_i(t_k), .txn_req_side_i(t_rq),
    .txn_cpl_side_i(t_cp), .txn_dword_i(t_dw), .ev_valid_i(e_v), .ev_code_i(e_c),
    .ev_par_err_i(e_pe), .ad_i(a_i), .cbe_n_i(c_i), .par_i(p_i), .par64_i(p64_i),
    .ad_o(a_o), .cbe_n_o(c_o), .par_o(po), .par64_o(p64o), .perr_pri_o(pp),
    .perr_sec_o(ps), .serr_o(se), .resp_dt_o(dt), .resp_split_o(sp), .fwd_o(fw),
    .fwd_bad_par_o(fb), .discard_o(dc), .disconnect_o(dn), .fetch_more_o(fm),
    .scm_valid_o(sv), .scm_class_o(cls), .scm_index_o(idx), .scm_replace_o(rp));

  sbeh_agent_model i_sbeh_agent_model (
    .clk_i(clk), .txn_start_o(t_st), .txn_kind_o(t_k), .txn_req_side_o(t_rq),
    .txn_cpl_side_o(t_cp), .txn_dword_o(t_dw), .ev_valid_o(e_v), .ev_code_o(e_c),
    .ev_par_err_o(e_pe), .ad_o(a_i), .cbe_n_o(c_i), .par_o(p_i), .par64_o(p64_i));

  // compare and count
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [31:0] exp, input logic eerr);
    int          n;
    logic [31:0] rd;
    logic        er;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    for (n = 0; n < 20 && pready !== 1'h1; n++) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n == 20) begin
      error_cnt++;
      test_done();
    end else begin
      if (!wr) chk(rd, exp, "prdata");
      chk(er, eerr, "pslverr");
    end
  endtask

  // clear both status registers
  task automatic clr();
    apb(1'h1, `SBEH_OFF_PSTAT, 32'h1F, 32'h0, 1'h0);
    apb(1'h1, `SBEH_OFF_SSTAT, 32'h1F, 32'h0, 1'h0);
  endtask

  // one event, then the registered answer and the forwarded data phase
  task automatic step(input sbeh_event_e c, input logic pe, input logic [9:0] exp);
    pat = {pat[62:0], ~pat[63]};
    i_sbeh_agent_model.send_ev(c, pe, pat);
    chk(obs, exp, "event outputs");
    chk(a_o, pat, "ad_o");
    chk({c_o, po, p64o}, {pat[7:0], (^pat) ^ pe, pe}, "cbe_n par");
  endtask

  // main sequence
  initial begin
    {rst_n, psel, penable, pwrite} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pat = 64'h0123_4567_89AB_CDEF;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    #1;
    chk(cls, `SBEH_SCM_CLASS, "scm_class_o");
    for (int i = 0; i < 3; i++) apb(1'h0, 12'(i * 4), 32'h0, 32'h0, 1'h0);
    apb(1'h0, 12'h00C, 32'h0, 32'h0, 1'h1);
    apb(1'h1, 12'h00C, 32'h7, 32'h0, 1'h1);
    apb(1'h0, `SBEH_OFF_CTRL, 32'h0, 32'h0, 1'h0);
    // master-abort with mode bit clear and set
    for (int m = 0; m < 2; m++) begin
      apb(1'h1, `SBEH_OFF_CTRL, 32'(5 + 2 * m), 32'h0, 1'h0);
      i_sbeh_agent_model.start(SBEH_KIND_READ, 1'h0, 1'h1, m[0]);
      step(SBEH_EV_DEST_PERR, 1'h0, 10'h108);
      chk(fm, 1'h1, "fetch_more_o");
      step(SBEH_EV_DEST_MA, 1'h0, 10'h001);
      chk({cls, idx, rp}, {`SBEH_SCM_CLASS, `SBEH_IDX_MA, m[0]}, "scm");
      i_sbeh_agent_model.start(SBEH_KIND_PW, 1'h0, 1'h1, 1'h0);
      step(SBEH_EV_DEST_MA, 1'h0, m ? 10'h086 : 10'h006);
      apb(1'h0, `SBEH_OFF_SSTAT, 32'h0, 32'h07, 1'h0);
      apb(1'h0, `SBEH_OFF_PSTAT, 32'h0, m ? 32'h10 : 32'h0, 1'h0);
      clr();
    end
    // non-posted write, forwarded, destination parity error
    i_sbeh_agent_model.start(SBEH_KIND_NPW, 1'h0, 1'h1, 1'h0);
    step(SBEH_EV_ORIG_DATA, 1'h0, 10'h030);
    step(SBEH_EV_DEST_PERR, 1'h0, 10'h000);
    apb(1'h0, `SBEH_OFF_SSTAT, 32'h0, 32'h02, 1'h0);
    step(SBEH_EV_DEST_DONE, 1'h0, 10'h001);
    chk({cls, idx}, {`SBEH_SCM_CLASS, `SBEH_IDX_WPAR}, "scm");
    i_sbeh_agent_model.start(SBEH_KIND_NPW, 1'h0, 1'h1, 1'h0);
    step(SBEH_EV_ORIG_DATA, 1'h0, 10'h030);
    step(SBEH_EV_DEST_PERR, 1'h0, 10'h000);
    step(SBEH_EV_DEST_SPLIT, 1'h0, 10'h000);
    // non-posted write with bad parity is discarded
    i_sbeh_agent_model.start(SBEH_KIND_NPW, 1'h0, 1'h1, 1'h0);
    step(SBEH_EV_ORIG_DATA, 1'h1, 10'h244);
    // posted writes with and without originating parity error
    i_sbeh_agent_model.start(SBEH_KIND_PW, 1'h0, 1'h1, 1'h0);
    step(SBEH_EV_ORIG_DATA, 1'h1, 10'h218);
    step(SBEH_EV_DEST_PERR, 1'h0, 10'h000);
    i_sbeh_agent_model.start(SBEH_KIND_PW, 1'h0, 1'h1, 1'h0);
    step(SBEH_EV_ORIG_DATA, 1'h0, 10'h010);
    step(SBEH_EV_DEST_PERR, 1'h0, 10'h080);
    // split completions and completion messages
    i_sbeh_agent_model.start(SBEH_KIND_SC, 1'h0, 1'h1, 1'h0);
    step(SBEH_EV_ORIG_DATA, 1'h1, 10'h118);
    step(SBEH_EV_DEST_PERR, 1'h0, 10'h000);
    i_sbeh_agent_model.start(SBEH_KIND_SCM, 1'h1, 1'h0, 1'h0);
    step(SBEH_EV_ORIG_DATA, 1'h1, 10'h084);
    i_sbeh_agent_model.start(SBEH_KIND_SCM, 1'h0, 1'h1, 1'h0);
    step(SBEH_EV_ORIG_DATA, 1'h0, 10'h010);
    // no discard option: early split response, bad data still forwarded
    apb(1'h1, `SBEH_OFF_CTRL, 32'h3, 32'h0, 1'h0);
    i_sbeh_agent_model.start(SBEH_KIND_NPW, 1'h0, 1'h1, 1'h1);
    chk(sp, 1'h1, "resp_split_o");
    step(SBEH_EV_ORIG_DATA, 1'h1, 10'h218);
    step(SBEH_EV_DEST_MA, 1'h0, 10'h001);
    chk({idx, rp}, {`SBEH_IDX_MA, 1'h1}, "scm");
    clr();
    i_sbeh_agent_model.start(SBEH_KIND_SC, 1'h1, 1'h0, 1'h0);
    step(SBEH_EV_DEST_MA, 1'h0, 10'h084);
    apb(1'h0, `SBEH_OFF_SSTAT, 32'h0, 32'h0C, 1'h0);
    apb(1'h0, `SBEH_OFF_PSTAT, 32'h0, 32'h10, 1'h0);
    clr();
    apb(1'h0, `SBEH_OFF_PSTAT, 32'h0, 32'h0, 1'h0);
    test_done();
  end
endmodule
